// file: bench/tb_top.sv
// self-checking bench for the pin output mux and overflow flags
module tb_top
   import pom_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // -----------------------------------------------------------------
   // stimulus, models and counters
   // -----------------------------------------------------------------
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic dir = 1'b0;
   logic [15:0] src = 16'h0000;   // source bits indexed by selector code
   logic dsp_clk = 1'b0;
   logic [4:0] ovf_ev = 5'h00;
   logic [7:0] reg_rdata_o;
   logic pin;
   logic pin_oe_n;
   logic [7:0] m55 = 8'h00;
   logic [7:0] m56 = 8'h00;
   logic [7:0] m57 = 8'h00;
   logic [4:0] ovf_m = 5'h00;
   logic [7:0] last_rd = 8'h00;
   logic [15:0] seed = 16'h5b39;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   // clock, one half period per inversion
   always #10 clock_i = ~clock_i;

   pom_pin_mux u_dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .pin3_dir_out_i(dir), .dsp_pin_i(src[1]),
      .amute_left_i(src[4]), .amute_right_i(src[5]),
      .clk_invalid_i(src[6]), .serial_audio_out_i(src[7]),
      .anmute_left_n_i(src[8]), .anmute_right_n_i(src[9]),
      .pll_lock_i(src[10]), .cp_clk_i(src[11]), .dac_clk_i(src[12]),
      .dsp_clk_i(dsp_clk), .uv_high_i(src[14]), .uv_low_i(src[15]),
      .left_port1_overflow_i(ovf_ev[4]), .right_port1_overflow_i(ovf_ev[3]),
      .left_port2_overflow_i(ovf_ev[2]), .right_port2_overflow_i(ovf_ev[1]),
      .shifter_overflow_i(ovf_ev[0]),
      .general_pin_three_o(pin), .general_pin_three_oe_n_o(pin_oe_n)
   );

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic summarize();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t ns: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask : chk

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   // expected register contents, reserved bits always read back as zero
   function automatic logic [7:0] regval(input logic [7:0] a);
      case (a)
         OFS_PIN3_SOURCE_SELECT: return m55;
         OFS_PIN_DRIVE_LEVEL: return m56;
         OFS_PIN_POLARITY_INVERT: return m57;
         OFS_PROCESSOR_OVERFLOW_STATUS: return {3'b000, ovf_m};
         default: return READ_ZERO;
      endcase
   endfunction : regval

   // one bus cycle, entered and left at a falling edge
   task automatic acc(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d, input logic [4:0] ev);
      reg_wr_i = w;
      reg_rd_i = r;
      reg_addr_i = a;
      reg_wdata_i = d;
      ovf_ev = ev;
      @(negedge clock_i);
   endtask : acc

   task automatic idle();
      acc(1'b0, 1'b0, 8'h00, 8'h00, 5'h00);
   endtask : idle

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, 1'b0, a, d, 5'h00);
      case (a)
         OFS_PIN3_SOURCE_SELECT: m55 = d & 8'h0f;
         OFS_PIN_DRIVE_LEVEL: m56 = d & 8'h3c;
         OFS_PIN_POLARITY_INVERT: m57 = d & 8'h3c;
         default: ;
      endcase
   endtask : wr

   // read data is registered, so it is settled at the next falling edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, 1'b1, a, 8'h00, 5'h00);
      chk(reg_rdata_o, exp); // registered read data
      last_rd = exp;
      if (a == OFS_PROCESSOR_OVERFLOW_STATUS)
         ovf_m = 5'h00;
   endtask : rd

   task automatic rdall();
      logic [7:0] a [5];
      a = '{OFS_PIN3_SOURCE_SELECT, OFS_PIN_DRIVE_LEVEL,
            OFS_PIN_POLARITY_INVERT, OFS_PROCESSOR_OVERFLOW_STATUS, 8'h58};
      for (int i = 0; i < 5; i++)
         rd(a[i], regval(a[i])); // readback values
   endtask : rdall

   // random sources, direction, sparse events and occasional status reads
   task automatic step();
      logic [15:0] r;
      logic rd5a;
      logic exp_pin;
      logic [7:0] exp_rd;
      seed = lfsr_next(seed);
      r = seed;
      seed = lfsr_next(seed);
      rd5a = seed[0] & seed[1];
      src = r;
      dir = seed[2];
      case (m55[3:0])
         SEL_OFF: exp_pin = 1'b0;
         SEL_LEVEL: exp_pin = m56[PIN3_BIT];
         SEL_AMUTE_BOTH: exp_pin = r[4] & r[5];
         default: exp_pin = r[m55[3:0]];
      endcase
      exp_pin = exp_pin ^ m57[PIN3_BIT];
      exp_rd = rd5a ? {3'b000, ovf_m} : last_rd;
      ovf_m = (rd5a ? 5'h00 : ovf_m) | (seed[15:11] & seed[10:6]);
      acc(1'b0, rd5a, OFS_PROCESSOR_OVERFLOW_STATUS, 8'h00,
          seed[15:11] & seed[10:6]);
      chk({7'h00, pin}, {7'h00, exp_pin}); // selected xor invert
      chk({7'h00, pin_oe_n}, {7'h00, ~dir}); // drive only as output
      chk(reg_rdata_o, exp_rd); // flags read then cleared
      last_rd = exp_rd;
   endtask : step

   // -----------------------------------------------------------------
   // timeout, well above the under 700 cycles the run needs
   // -----------------------------------------------------------------
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         summarize();
      end
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial
   begin
      int edges;
      logic prev;
      repeat (20) @(negedge clock_i);
      rst_n_i = 1'b1;
      chk({7'h00, pin}, 8'h00); // pin low out of reset
      chk({7'h00, pin_oe_n}, 8'h01); // not driving out of reset
      rdall();
      // defined bits only, status register ignores writes
      wr(OFS_PIN3_SOURCE_SELECT, 8'h0f);
      wr(OFS_PIN_DRIVE_LEVEL, 8'h3c);
      wr(OFS_PIN_POLARITY_INVERT, 8'h3c);
      wr(OFS_PROCESSOR_OVERFLOW_STATUS, 8'h1f);
      rdall();
      // every code but the divided clock, both polarities, random levels
      for (int c = 0; c < 32; c++)
      begin
         if (c[3:0] == SEL_DSP_DIV4)
            continue;
         seed = lfsr_next(seed);
         // reserved bits kept clear, bit five inverts on second pass
         wr(OFS_PIN3_SOURCE_SELECT, {4'h0, c[3:0]});
         wr(OFS_PIN_DRIVE_LEVEL, seed[15:8] & 8'h3c);
         wr(OFS_PIN_POLARITY_INVERT, {2'b00, c[4], seed[3:1], 2'b00});
         idle();
         idle();
         repeat (12) step();
      end
      rdall();
      // processor clock over four: half period of eight cycles
      wr(OFS_PIN3_SOURCE_SELECT, {4'h0, SEL_DSP_DIV4});
      wr(OFS_PIN_POLARITY_INVERT, 8'h00);
      edges = 0;
      prev = pin;
      for (int i = 0; i < 80; i++)
      begin
         dsp_clk = i[1];   // kept well below half the system clock
         idle();
         if (i >= 16 && pin !== prev)
            edges++;
         prev = pin;
      end
      chk(8'(edges), 8'h08); // divided clock rate
      // one event per flag bit, held after the event and cleared by read
      for (int i = 0; i < 5; i++)
      begin
         acc(1'b0, 1'b0, 8'h00, 8'h00, 5'(1 << i));
         ovf_m = 5'(1 << i);
         idle();
         rd(OFS_PROCESSOR_OVERFLOW_STATUS, {3'b000, ovf_m});
         rd(OFS_PROCESSOR_OVERFLOW_STATUS, 8'h00); // cleared by read
      end
      // second reset in mid-run with registers and flags populated
      wr(OFS_PIN3_SOURCE_SELECT, 8'h02);
      wr(OFS_PIN_DRIVE_LEVEL, 8'h3c);
      acc(1'b0, 1'b0, 8'h00, 8'h00, 5'h1f);
      rst_n_i = 1'b0;
      dir = 1'b1;
      idle();
      idle();
      rst_n_i = 1'b1;
      m55 = 8'h00;
      m56 = 8'h00;
      m57 = 8'h00;
      ovf_m = 5'h00;
      chk({7'h00, pin}, 8'h00); // pin low after reset
      chk({7'h00, pin_oe_n}, 8'h01); // enable released in reset
      rdall();
      summarize();
   end

endmodule : tb_top

// file: rtl/pom_ovf_flags.sv
// sticky clear-on-read overflow flags
module pom_ovf_flags
   import pom_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // flag carrier
   pom_ovf_if.owner ovf
);

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // -----------------------------------------------------------------
   // one sticky flag per source
   // -----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < OVF_W; gi++)
      begin : g_flag
         always_ff @(posedge clock_i)
         begin
            if (!rst_n_i)
               ovf.flags[gi] <= OVF_RESET[gi];
            else if (ovf.event_set[gi])
               ovf.flags[gi] <= 1'b1;
            else if (ovf.rd_clear)
               ovf.flags[gi] <= 1'b0;
         end

         a_flag_sticky_hold: assert property (
            ovf.flags[gi] && !ovf.rd_clear |=> ovf.flags[gi])
            else $error("overflow flag dropped without a read");
         a_flag_read_clear: assert property (
            ovf.rd_clear && !ovf.event_set[gi] |=> !ovf.flags[gi])
            else $error("overflow flag not cleared by read");
         a_flag_set_wins: assert property (
            ovf.event_set[gi] |=> ovf.flags[gi] [*1])
            else $error("overflow event lost");
      end
   endgenerate

endmodule : pom_ovf_flags

// file: rtl/pom_pin_mux.sv
// output source mux, polarity and register port for general pin three

// -----------------------------------------------------------------
// top module
// -----------------------------------------------------------------
module pom_pin_mux
   import pom_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   // direction from the separate direction register
   input wire logic pin3_dir_out_i,
   // internal sources
   input wire logic dsp_pin_i,
   input wire logic amute_left_i,
   input wire logic amute_right_i,
   input wire logic clk_invalid_i,
   input wire logic serial_audio_out_i,
   input wire logic anmute_left_n_i,
   input wire logic anmute_right_n_i,
   input wire logic pll_lock_i,
   input wire logic cp_clk_i,
   input wire logic dac_clk_i,
   input wire logic dsp_clk_i,
   input wire logic uv_high_i,
   input wire logic uv_low_i,
   // overflow events from the processor
   input wire logic left_port1_overflow_i,
   input wire logic right_port1_overflow_i,
   input wire logic left_port2_overflow_i,
   input wire logic right_port2_overflow_i,
   input wire logic shifter_overflow_i,
   // pin
   output logic general_pin_three_o,
   output logic general_pin_three_oe_n_o
);

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic [SEL_W-1:0] pin3_source_code;
   logic [GP_W-1:0] pin_level_bits;
   logic [GP_W-1:0] pin_invert_bits;
   logic [1:0] dsp_div_cnt;
   logic dsp_clk_prev;
   logic dsp_clk_rise;
   logic sel_src;
   logic next_pin;
   logic [DATA_W-1:0] next_rdata;
   logic wr_sel;
   logic wr_level;
   logic wr_invert;
   logic rd_ovf;

   pom_ovf_if ovf ();

   // -----------------------------------------------------------------
   // register decode
   // -----------------------------------------------------------------
   // reserved bits are simply not stored, so a stray write is harmless
   assign wr_sel = reg_wr_i && (reg_addr_i == OFS_PIN3_SOURCE_SELECT);
   assign wr_level = reg_wr_i && (reg_addr_i == OFS_PIN_DRIVE_LEVEL);
   assign wr_invert = reg_wr_i && (reg_addr_i == OFS_PIN_POLARITY_INVERT);
   // a read of the status register clears it
   assign rd_ovf = reg_rd_i && (reg_addr_i == OFS_PROCESSOR_OVERFLOW_STATUS);

   // selector, low nibble, resets to off
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         pin3_source_code <= SEL_RESET;
      else if (wr_sel)
         pin3_source_code <= reg_wdata_i[SEL_MSB:SEL_LSB];
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         pin_level_bits <= GP_RESET;
      else if (wr_level)
         pin_level_bits <= reg_wdata_i[GP_MSB:GP_LSB];
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         pin_invert_bits <= GP_RESET;
      else if (wr_invert)
         pin_invert_bits <= reg_wdata_i[GP_MSB:GP_LSB];
   end

   // -----------------------------------------------------------------
   // read data
   // -----------------------------------------------------------------
   // unmapped offsets and reserved bits read as zero
   always_comb
   begin
      next_rdata = READ_ZERO;
      if (reg_addr_i == OFS_PIN3_SOURCE_SELECT)
         next_rdata[SEL_MSB:SEL_LSB] = pin3_source_code;
      else if (reg_addr_i == OFS_PIN_DRIVE_LEVEL)
         next_rdata[GP_MSB:GP_LSB] = pin_level_bits;
      else if (reg_addr_i == OFS_PIN_POLARITY_INVERT)
         next_rdata[GP_MSB:GP_LSB] = pin_invert_bits;
      else if (reg_addr_i == OFS_PROCESSOR_OVERFLOW_STATUS)
         next_rdata[OVF_W-1:0] = ovf.flags;
   end

   // read data held until the next read
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= READ_ZERO;
      else if (reg_rd_i)
         reg_rdata_o <= next_rdata;
   end

   // -----------------------------------------------------------------
   // overflow flags
   // -----------------------------------------------------------------
   // ports one and two left and right, the shifter, and the read clear
   assign ovf.event_set[OVF_LEFT1] = left_port1_overflow_i;
   assign ovf.event_set[OVF_RIGHT1] = right_port1_overflow_i;
   assign ovf.event_set[OVF_LEFT2] = left_port2_overflow_i;
   assign ovf.event_set[OVF_RIGHT2] = right_port2_overflow_i;
   assign ovf.event_set[OVF_SHIFTER] = shifter_overflow_i;
   assign ovf.rd_clear = rd_ovf;

   pom_ovf_flags u_flags (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .ovf (ovf.owner)
   );

   // -----------------------------------------------------------------
   // processor clock divided by four
   // -----------------------------------------------------------------
   // sampled in the system clock, so it must stay below half rate
   assign dsp_clk_rise = dsp_clk_i && !dsp_clk_prev;

   // edge detect register for the processor clock
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         dsp_clk_prev <= 1'b0;
      else
         dsp_clk_prev <= dsp_clk_i;
   end

   // count rising edges, msb is clk/4
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         dsp_div_cnt <= DIV_RESET;
      else if (dsp_clk_rise)
         dsp_div_cnt <= dsp_div_cnt + DIV_STEP;
   end

   // -----------------------------------------------------------------
   // source mux
   // -----------------------------------------------------------------
   // every code is legal, so no default arm
   always_comb
   begin
      sel_src = 1'b0;
      unique case (pin3_source_code)
         SEL_OFF: sel_src = 1'b0;
         SEL_DSP_PIN: sel_src = dsp_pin_i;
         SEL_LEVEL: sel_src = pin_level_bits[PIN3_IDX];
         SEL_AMUTE_BOTH: sel_src = amute_left_i && amute_right_i;
         SEL_AMUTE_LEFT: sel_src = amute_left_i;
         SEL_AMUTE_RIGHT: sel_src = amute_right_i;
         SEL_CLK_INVALID: sel_src = clk_invalid_i;
         SEL_SERIAL_OUT: sel_src = serial_audio_out_i;
         SEL_ANMUTE_LEFT: sel_src = anmute_left_n_i;
         SEL_ANMUTE_RIGHT: sel_src = anmute_right_n_i;
         SEL_PLL_LOCK: sel_src = pll_lock_i;
         SEL_CP_CLK: sel_src = cp_clk_i;
         SEL_DAC_CLK: sel_src = dac_clk_i;
         SEL_DSP_DIV4: sel_src = dsp_div_cnt[1];
         SEL_UV_HIGH: sel_src = uv_high_i;
         SEL_UV_LOW: sel_src = uv_low_i;
      endcase
   end

   assign next_pin = sel_src ^ pin_invert_bits[PIN3_IDX];

   // -----------------------------------------------------------------
   // pin drivers
   // -----------------------------------------------------------------
   // one flop of latency so the pin never glitches on a mux change
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         general_pin_three_o <= 1'b0;
      else
         general_pin_three_o <= next_pin;
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         general_pin_three_oe_n_o <= 1'b1;
      else
         general_pin_three_oe_n_o <= !pin3_dir_out_i;
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_reset_pin_low: assert property (
      $rose(rst_n_i) |-> !general_pin_three_o && pin3_source_code == SEL_OFF)
      else $error("pin not low after reset");
   a_dir_gates_pin: assert property (
      !pin3_dir_out_i |=> general_pin_three_oe_n_o)
      else $error("pin driven while direction is input");
   a_level_route: assert property (
      pin3_source_code == SEL_LEVEL && !pin_invert_bits[PIN3_IDX]
      |=> general_pin_three_o == $past(pin_level_bits[PIN3_IDX]))
      else $error("level bit not on pin");
   a_both_mute_and: assert property (
      pin3_source_code == SEL_AMUTE_BOTH && !pin_invert_bits[PIN3_IDX]
      && amute_left_i && !amute_right_i |=> !general_pin_three_o)
      else $error("both-muted flag set with one channel only");
   a_anmute_low_act: assert property (
      pin3_source_code == SEL_ANMUTE_LEFT && !pin_invert_bits[PIN3_IDX]
      |=> general_pin_three_o == $past(anmute_left_n_i))
      else $error("analog mute flag polarity wrong");
   a_invert_flips: assert property (
      pin3_source_code == SEL_OFF && pin_invert_bits[PIN3_IDX]
      |=> general_pin_three_o)
      else $error("inverted off code not high");
   a_div4_counts: assert property (
      dsp_clk_rise |=> dsp_div_cnt == $past(dsp_div_cnt) + DIV_STEP)
      else $error("processor clock divider missed an edge");
   a_ovf_readback: assert property (
      rd_ovf |=> reg_rdata_o == {3'b000, $past(ovf.flags)})
      else $error("overflow status readback wrong");
   a_sel_write: assert property (
      wr_sel ##1 !wr_sel [*2]
      |-> pin3_source_code == $past(reg_wdata_i[SEL_MSB:SEL_LSB], 2))
      else $error("selector write not held");

endmodule : pom_pin_mux

// file: shared/pom_ovf_if.sv
// carrier between the register logic and the sticky overflow flags
interface pom_ovf_if;
   logic [4:0] event_set;   // one bit per overflow source
   logic rd_clear;          // status register read this cycle
   logic [4:0] flags;       // sticky flag state

   modport owner (input event_set, input rd_clear, output flags);
   modport user (output event_set, output rd_clear, input flags);
endinterface : pom_ovf_if

// file: shared/pom_pkg.sv
// constants for the pin output mux and overflow flag block
package pom_pkg;

   // -----------------------------------------------------------------
   // register bus widths and offsets
   // -----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] OFS_PIN3_SOURCE_SELECT = 8'h55;
   localparam logic [7:0] OFS_PIN_DRIVE_LEVEL = 8'h56;
   localparam logic [7:0] OFS_PIN_POLARITY_INVERT = 8'h57;
   localparam logic [7:0] OFS_PROCESSOR_OVERFLOW_STATUS = 8'h5a;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // -----------------------------------------------------------------
   // field layouts
   // -----------------------------------------------------------------
   localparam int SEL_W = 4;
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 3;
   localparam int GP_LSB = 2;          // level and invert fields, b5..b2
   localparam int GP_MSB = 5;
   localparam int GP_W = 4;
   localparam int PIN3_BIT = 5;        // this pin's bit in both fields
   localparam int PIN3_IDX = PIN3_BIT - GP_LSB;
   localparam int OVF_W = 5;
   localparam int OVF_SHIFTER = 0;
   localparam int OVF_RIGHT2 = 1;
   localparam int OVF_LEFT2 = 2;
   localparam int OVF_RIGHT1 = 3;
   localparam int OVF_LEFT1 = 4;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [3:0] SEL_RESET = 4'h0;
   localparam logic [3:0] GP_RESET = 4'h0;
   localparam logic [4:0] OVF_RESET = 5'h00;
   localparam logic [1:0] DIV_RESET = 2'h0;
   localparam logic [1:0] DIV_STEP = 2'h1;

   // -----------------------------------------------------------------
   // source selector codes
   // -----------------------------------------------------------------
   localparam logic [3:0] SEL_OFF = 4'h0;
   localparam logic [3:0] SEL_DSP_PIN = 4'h1;
   localparam logic [3:0] SEL_LEVEL = 4'h2;
   localparam logic [3:0] SEL_AMUTE_BOTH = 4'h3;
   localparam logic [3:0] SEL_AMUTE_LEFT = 4'h4;
   localparam logic [3:0] SEL_AMUTE_RIGHT = 4'h5;
   localparam logic [3:0] SEL_CLK_INVALID = 4'h6;
   localparam logic [3:0] SEL_SERIAL_OUT = 4'h7;
   localparam logic [3:0] SEL_ANMUTE_LEFT = 4'h8;
   localparam logic [3:0] SEL_ANMUTE_RIGHT = 4'h9;
   localparam logic [3:0] SEL_PLL_LOCK = 4'ha;
   localparam logic [3:0] SEL_CP_CLK = 4'hb;
   localparam logic [3:0] SEL_DAC_CLK = 4'hc;
   localparam logic [3:0] SEL_DSP_DIV4 = 4'hd;
   localparam logic [3:0] SEL_UV_HIGH = 4'he;
   localparam logic [3:0] SEL_UV_LOW = 4'hf;

endpackage : pom_pkg
